//--- logic/sbc_regs.svh
/*
 * Offsets, field positions, reset values and timing counts of the burst capture sequencer.
 * Assumes a 50 MHz aclk shared by both ends.
 */
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH
// Device register indices on the parallel link
`define SBC_DEV_CTRL     3'h0
`define SBC_DEV_STAT     3'h1
`define SBC_DEV_DATA0    3'h4
// Device control fields
`define SBC_CF_CYC_LSB   0
`define SBC_CF_CYC_MSB   3
`define SBC_CF_MODE_LSB  4
`define SBC_CF_MODE_MSB  5
`define SBC_CF_NB_LSB    6
`define SBC_CF_NB_MSB    7
`define SBC_CTRL_RST     10'h004
`define SBC_CYC_MIN      4'h4
// Sequencing counts
`define SBC_OPEN_EDGES   2'h2
`define SBC_CONV_CYC     4'hE
`define SBC_SYNC_CYC     4'h2
`define SBC_FLAG_CYC     4'h1
// Times in ns and derived cycle counts
`define SBC_CLK_NS       20
`define SBC_SETUP_NS     200
`define SBC_DISCH_NS     300
`define SBC_SETUP_CYC    ((`SBC_SETUP_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`define SBC_DISCH_CYC    ((`SBC_DISCH_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
// Host register byte offsets
`define SBC_H_CTRL       8'h00
`define SBC_H_CMD        8'h04
`define SBC_H_TIME       8'h08
`define SBC_H_STAT       8'h0C
`define SBC_H_DATA0      8'h10
`define SBC_H_IRQ_STAT   8'h20
`define SBC_H_IRQ_CLR    8'h24
`define SBC_H_IRQ_EN     8'h28
`define SBC_TIME_RST     32'h0008_0008
`endif

//--- logic/sbc_pkg.sv
/*
 * Types shared by both ends of the burst capture sequencer.
 * Assumes sbc_regs.svh supplies the numeric constants.
 */
package sbc_pkg;
	typedef enum logic [1:0] {SBC_M_SYNC, SBC_M_GATED, SBC_M_CAL} sbc_mode_t;
	typedef enum {SBC_D_WAITG, SBC_D_ARM, SBC_D_INT, SBC_D_HOLD, SBC_D_SYNC, SBC_D_CONV,
		SBC_D_FLAG} sbc_dst_t;
	typedef enum {SBC_H_IDLE, SBC_H_WR, SBC_H_SETUP, SBC_H_ALIGN, SBC_H_GHI, SBC_H_GLO,
		SBC_H_CWAIT, SBC_H_RD, SBC_H_RDW, SBC_H_DONE} sbc_hst_t;
endpackage : sbc_pkg

//--- logic/sbc_if.sv
/*
 * Link between host and sequencer: register strobes, capture gate, zero-cross level.
 * Assumes the bench drives zero_cross_out synchronous to aclk.
 */
`timescale 1ns/1ps
interface sbc_if;
	logic [2:0] bus_addr;
	logic [9:0] bus_wdata;
	logic       bus_wr;
	logic       bus_rd;
	logic [9:0] bus_rdata;
	logic       capture_gate;
	logic       zero_cross_out;
	modport dev (input bus_addr, bus_wdata, bus_wr, bus_rd, capture_gate, zero_cross_out,
		output bus_rdata);
	modport host (output bus_addr, bus_wdata, bus_wr, bus_rd, capture_gate,
		input bus_rdata, zero_cross_out);
endinterface : sbc_if

//--- logic/sbc_dev.sv
/*
 * Device end: burst capture windowing, hold and conversion sequencing, register file.
 * Assumes aclk is the conversion clock and all link inputs are synchronous to it.
 */
`timescale 1ns/1ps
`include "sbc_regs.svh"
module sbc_dev import sbc_pkg::*; #(
	parameter int DW = 10,
	parameter int NB = 4
) (
	// Clock and reset
	input wire logic          aclk,
	input wire logic          aresetn,
	// Link to host
	sbc_if.dev                lnk,
	// Analog front end
	input wire logic [DW-1:0] sample_in,
	output logic              integrate,
	output logic              discharge_sw,
	output logic              conv_done
);
	sbc_dst_t        st_q, st_d;
	logic [9:0]      ctrl_q, ctrl_d;
	logic            busy_q, busy_d;
	logic            gate_q, zc_q;
	logic            int_q, int_d;
	logic            dis_q, dis_d;
	logic            done_q, done_d;
	logic [1:0]      edge_q, edge_d;
	logic [3:0]      cnt_q, cnt_d;
	logic [1:0]      bidx_q, bidx_d;
	logic [DW-1:0]   held_q [NB];
	logic [DW-1:0]   held_d [NB];
	logic [DW-1:0]   data_q [NB];
	logic [DW-1:0]   data_d [NB];
	logic [9:0]      rdata_q, rdata_d;
	logic [3:0]      ncyc;
	logic [1:0]      nlast;
	sbc_mode_t       mode;
	logic            gate_rise, gate_fall, zc_fall, end_burst;

	assign integrate    = int_q;
	assign discharge_sw = dis_q;
	assign conv_done    = done_q;
	assign lnk.bus_rdata = rdata_q;

	always_comb begin
		ncyc = ctrl_q[`SBC_CF_CYC_MSB:`SBC_CF_CYC_LSB];
		if (ncyc < `SBC_CYC_MIN) begin
			ncyc = `SBC_CYC_MIN;
		end
		nlast = ctrl_q[`SBC_CF_NB_MSB:`SBC_CF_NB_LSB];
		case (ctrl_q[`SBC_CF_MODE_MSB:`SBC_CF_MODE_LSB])
			2'h1:    mode = SBC_M_GATED;
			2'h2:    mode = SBC_M_CAL;
			default: mode = SBC_M_SYNC;
		endcase
		gate_rise = lnk.capture_gate & ~gate_q;
		gate_fall = ~lnk.capture_gate & gate_q;
		zc_fall   = zc_q & ~lnk.zero_cross_out;
	end

	always_comb begin
		st_d      = st_q;
		ctrl_d    = ctrl_q;
		busy_d    = busy_q;
		int_d     = int_q;
		done_d    = 1'b0;
		edge_d    = edge_q;
		cnt_d     = cnt_q;
		bidx_d    = bidx_q;
		held_d    = held_q;
		data_d    = data_q;
		end_burst = 1'b0;
		if (lnk.bus_wr && lnk.bus_addr == `SBC_DEV_CTRL) begin
			ctrl_d = lnk.bus_wdata;
		end
		unique case (st_q)
			SBC_D_WAITG: begin
				if (gate_rise) begin
					busy_d = 1'b1;
					edge_d = 2'h0;
					cnt_d  = 4'h0;
					if (mode == SBC_M_SYNC) begin
						st_d = SBC_D_ARM;
					end else begin
						int_d = 1'b1;
						st_d  = SBC_D_INT;
					end
				end
			end
			SBC_D_ARM: begin
				if (gate_fall) begin
					end_burst = 1'b1;
				end else if (zc_fall) begin
					edge_d = edge_q + 2'h1;
					if (edge_q == `SBC_OPEN_EDGES - 2'h1) begin
						int_d = 1'b1;
						st_d  = SBC_D_INT;
					end
				end
			end
			SBC_D_INT: begin
				if (gate_fall) begin
					end_burst = 1'b1;
				end else if (mode == SBC_M_SYNC && zc_fall) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == ncyc - 4'h1) begin
						int_d = 1'b0;
						st_d  = SBC_D_HOLD;
					end
				end
			end
			SBC_D_HOLD: begin
				if (gate_fall) begin
					end_burst = 1'b1;
				end
			end
			SBC_D_SYNC: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == `SBC_SYNC_CYC - 4'h1) begin
					cnt_d  = 4'h0;
					bidx_d = 2'h0;
					st_d   = SBC_D_CONV;
				end
			end
			SBC_D_CONV: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == `SBC_CONV_CYC - 4'h1) begin
					cnt_d          = 4'h0;
					data_d[bidx_q] = held_q[bidx_q];
					bidx_d         = bidx_q + 2'h1;
					if (bidx_q == nlast) begin
						st_d = SBC_D_FLAG;
					end
				end
			end
			SBC_D_FLAG: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == `SBC_FLAG_CYC - 4'h1) begin
					busy_d = 1'b0;
					done_d = 1'b1;
					bidx_d = 2'h0;
					cnt_d  = 4'h0;
					st_d   = SBC_D_WAITG;
				end
			end
		endcase
		if (end_burst) begin
			int_d          = 1'b0;
			held_d[bidx_q] = sample_in;
			cnt_d          = 4'h0;
			if (bidx_q == nlast) begin
				st_d = SBC_D_SYNC;
			end else begin
				bidx_d = bidx_q + 2'h1;
				st_d   = SBC_D_WAITG;
			end
		end
		// Discharge only while waiting for a window, never in calibration
		dis_d = (mode != SBC_M_CAL) && !int_d && (st_d == SBC_D_WAITG || st_d == SBC_D_ARM)
			&& !(st_d == SBC_D_WAITG && busy_d && st_q != SBC_D_WAITG && !end_burst);
		rdata_d = 10'h000;
		if (lnk.bus_rd) begin
			if (lnk.bus_addr == `SBC_DEV_CTRL) begin
				rdata_d = ctrl_q;
			end else if (lnk.bus_addr == `SBC_DEV_STAT) begin
				rdata_d = {9'h000, busy_q};
			end else if (lnk.bus_addr >= `SBC_DEV_DATA0) begin
				rdata_d = 10'(data_q[2'(lnk.bus_addr - `SBC_DEV_DATA0)]);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q    <= SBC_D_WAITG;
			ctrl_q  <= `SBC_CTRL_RST;
			busy_q  <= 1'b0;
			gate_q  <= 1'b0;
			zc_q    <= 1'b0;
			int_q   <= 1'b0;
			dis_q   <= 1'b1;
			done_q  <= 1'b0;
			edge_q  <= 2'h0;
			cnt_q   <= 4'h0;
			bidx_q  <= 2'h0;
			rdata_q <= 10'h000;
			for (int i = 0; i < NB; i++) begin
				held_q[i] <= '0;
				data_q[i] <= '0;
			end
		end else begin
			st_q    <= st_d;
			ctrl_q  <= ctrl_d;
			busy_q  <= busy_d;
			gate_q  <= lnk.capture_gate;
			zc_q    <= lnk.zero_cross_out;
			int_q   <= int_d;
			dis_q   <= dis_d;
			done_q  <= done_d;
			edge_q  <= edge_d;
			cnt_q   <= cnt_d;
			bidx_q  <= bidx_d;
			rdata_q <= rdata_d;
			held_q  <= held_d;
			data_q  <= data_d;
		end
	end
endmodule : sbc_dev

//--- logic/sbc_host.sv
/*
 * Host end: AXI4-Lite register slave that programs the sequencer, gates bursts and reads results.
 * Assumes the sequencer sits on the same aclk across an sbc_if link.
 */
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sbc_regs.svh"
module sbc_host import sbc_pkg::*; (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// AXI4-Lite slave
	input wire logic [7:0]  s_awaddr,
	input wire logic        s_awvalid,
	output logic            s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0]  s_wstrb,
	input wire logic        s_wvalid,
	output logic            s_wready,
	output logic [1:0]      s_bresp,
	output logic            s_bvalid,
	input wire logic        s_bready,
	input wire logic [7:0]  s_araddr,
	input wire logic        s_arvalid,
	output logic            s_arready,
	output logic [31:0]     s_rdata,
	output logic [1:0]      s_rresp,
	output logic            s_rvalid,
	input wire logic        s_rready,
	// Interrupt
	output logic            irq,
	// Link to sequencer
	sbc_if.host             lnk
);
	sbc_hst_t    st_q, st_d;
	logic [9:0]  ctrl_q, ctrl_d, last_q, last_d;
	logic        align_q, align_d;
	logic [31:0] time_q, time_d;
	logic [9:0]  res_q [4];
	logic [9:0]  res_d [4];
	logic [1:0]  irqs_q, irqs_d, irqe_q, irqe_d;
	logic [15:0] cnt_q, cnt_d;
	logic [2:0]  idx_q, idx_d;
	logic [1:0]  nb_q, nb_d;
	logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, irq_d, zc_q;
	logic [7:0]  awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [2:0]  ba_q, ba_d;
	logic [9:0]  bw_q, bw_d;
	logic        bwr_q, bwr_d, brd_q, brd_d, gate_q, gate_d;
	logic        wr_go, go, was_cal, ev_done, ev_ref;
	logic        cal_q, cal_d, irq_q;

	assign s_awready = ~aw_q;
	assign s_wready  = ~w_q;
	assign s_bvalid  = bv_q;
	assign s_bresp   = 2'h0;
	assign s_arready = ~rv_q;
	assign s_rvalid  = rv_q;
	assign s_rdata   = rd_q;
	assign s_rresp   = 2'h0;
	assign irq       = irq_q;
	assign lnk.bus_addr  = ba_q;
	assign lnk.bus_wdata = bw_q;
	assign lnk.bus_wr    = bwr_q;
	assign lnk.bus_rd    = brd_q;
	assign lnk.capture_gate = gate_q;

	always_comb begin
		aw_d = aw_q | s_awvalid;
		w_d  = w_q | s_wvalid;
		awa_d = s_awvalid && !aw_q ? s_awaddr : awa_q;
		wd_d  = s_wvalid && !w_q ? s_wdata : wd_q;
		wr_go = aw_q && w_q && !bv_q;
		bv_d  = (bv_q && !s_bready) || wr_go;
		if (wr_go) begin
			aw_d = 1'b0;
			w_d  = 1'b0;
		end
		ctrl_d  = ctrl_q;
		align_d = align_q;
		time_d  = time_q;
		irqe_d  = irqe_q;
		go      = 1'b0;
		if (wr_go && s_wstrb[0]) begin
			case (awa_q)
				`SBC_H_CTRL:    {align_d, ctrl_d} = wd_q[10:0];
				`SBC_H_CMD:     go = wd_q[0];
				`SBC_H_TIME:    time_d = wd_q;
				`SBC_H_IRQ_EN:  irqe_d = wd_q[1:0];
				default: ;
			endcase
		end
		rv_d = (rv_q && !s_rready) || (s_arvalid && !rv_q);
		rd_d = rd_q;
		if (s_arvalid && !rv_q) begin
			case (s_araddr)
				`SBC_H_CTRL:     rd_d = {21'h0, align_q, ctrl_q};
				`SBC_H_TIME:     rd_d = time_q;
				`SBC_H_STAT:     rd_d = {30'h0, last_q[0], st_q != SBC_H_IDLE};
				`SBC_H_IRQ_STAT: rd_d = {30'h0, irqs_q};
				`SBC_H_IRQ_EN:   rd_d = {30'h0, irqe_q};
				default: begin
					rd_d = 32'h0;
					if (s_araddr[7:4] == 4'h1) begin
						rd_d = {22'h0, res_q[s_araddr[3:2]]};
					end
				end
			endcase
		end
	end

	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q + 16'h1;
		idx_d   = idx_q;
		nb_d    = nb_q;
		last_d  = last_q;
		res_d   = res_q;
		ba_d    = ba_q;
		bw_d    = bw_q;
		bwr_d   = 1'b0;
		brd_d   = 1'b0;
		gate_d  = gate_q;
		cal_d   = cal_q;
		ev_done = 1'b0;
		ev_ref  = 1'b0;
		was_cal = last_q[`SBC_CF_MODE_MSB:`SBC_CF_MODE_LSB] == 2'h2;
		unique case (st_q)
			SBC_H_IDLE: begin
				if (go) begin
					st_d  = SBC_H_WR;
					ba_d  = `SBC_DEV_STAT;
					brd_d = 1'b1;
				end
			end
			SBC_H_WR: begin
				if (brd_q) begin
					st_d = SBC_H_WR;
				end else if (lnk.bus_rdata[0]) begin
					ev_ref = 1'b1;
					st_d   = SBC_H_IDLE;
				end else begin
					ba_d   = `SBC_DEV_CTRL;
					bw_d   = ctrl_q;
					bwr_d  = 1'b1;
					last_d = ctrl_q;
					cal_d  = was_cal;
					nb_d   = ctrl_q[`SBC_CF_NB_MSB:`SBC_CF_NB_LSB];
					idx_d  = 3'h0;
					cnt_d  = 16'h0;
					st_d   = SBC_H_SETUP;
				end
			end
			SBC_H_SETUP: begin
				if (cnt_q >= 16'(`SBC_SETUP_CYC + (cal_q ? `SBC_DISCH_CYC : 0))) begin
					st_d = align_q ? SBC_H_ALIGN : SBC_H_GHI;
					cnt_d  = 16'h0;
					gate_d = !align_q;
				end
			end
			SBC_H_ALIGN: begin
				if (lnk.zero_cross_out && !zc_q) begin
					gate_d = 1'b1;
					cnt_d  = 16'h0;
					st_d   = SBC_H_GHI;
				end
			end
			SBC_H_GHI: begin
				if (cnt_q >= time_q[15:0]) begin
					gate_d = 1'b0;
					cnt_d  = 16'h0;
					st_d   = idx_q[1:0] == nb_q ? SBC_H_CWAIT : SBC_H_GLO;
				end
			end
			SBC_H_GLO: begin
				if (cnt_q >= time_q[31:16]) begin
					idx_d  = idx_q + 3'h1;
					cnt_d  = 16'h0;
					gate_d = !align_q;
					st_d   = align_q ? SBC_H_ALIGN : SBC_H_GHI;
				end
			end
			SBC_H_CWAIT: begin
				if (cnt_q >= 16'(({14'h0, nb_q} + 16'h1) * `SBC_CONV_CYC + `SBC_SYNC_CYC
					+ `SBC_FLAG_CYC + 1)) begin
					idx_d = 3'h0;
					st_d  = SBC_H_RD;
				end
			end
			SBC_H_RD: begin
				ba_d  = `SBC_DEV_DATA0 + idx_q;
				brd_d = 1'b1;
				st_d  = SBC_H_RDW;
			end
			SBC_H_RDW: begin
				if (!brd_q) begin
					res_d[idx_q[1:0]] = lnk.bus_rdata;
					idx_d = idx_q + 3'h1;
					st_d  = idx_q[1:0] == nb_q ? SBC_H_DONE : SBC_H_RD;
				end
			end
			SBC_H_DONE: begin
				ev_done = 1'b1;
				st_d    = SBC_H_IDLE;
			end
		endcase
		irqs_d = irqs_q;
		if (wr_go && awa_q == `SBC_H_IRQ_CLR) begin
			irqs_d = irqs_q & ~wd_q[1:0];
		end
		irqs_d = irqs_d | {ev_ref, ev_done};
		irq_d  = |(irqs_d & irqe_d);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= SBC_H_IDLE;
			ctrl_q <= `SBC_CTRL_RST;
			last_q <= `SBC_CTRL_RST;
			align_q <= 1'b0;
			time_q <= `SBC_TIME_RST;
			irqs_q <= 2'h0;
			irqe_q <= 2'h0;
			cnt_q <= 16'h0;
			idx_q <= 3'h0;
			nb_q <= 2'h0;
			{aw_q, w_q, bv_q, rv_q, zc_q} <= 5'h00;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			rd_q <= 32'h0;
			ba_q <= 3'h0;
			bw_q <= 10'h000;
			{bwr_q, brd_q, gate_q} <= 3'h0;
			cal_q <= 1'b0;
			irq_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				res_q[i] <= 10'h000;
			end
		end else begin
			st_q <= st_d;
			ctrl_q <= ctrl_d;
			last_q <= last_d;
			align_q <= align_d;
			time_q <= time_d;
			irqs_q <= irqs_d;
			irqe_q <= irqe_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			nb_q <= nb_d;
			{aw_q, w_q, bv_q, rv_q, zc_q} <= {aw_d, w_d, bv_d, rv_d, lnk.zero_cross_out};
			awa_q <= awa_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			ba_q <= ba_d;
			bw_q <= bw_d;
			{bwr_q, brd_q, gate_q} <= {bwr_d, brd_d, gate_d};
			cal_q <= cal_d;
			irq_q <= irq_d;
			res_q <= res_d;
		end
	end
endmodule : sbc_host

//--- dv/sbc_chk.sv
/*
 * Concurrent checks on the host to sequencer link and the sequencer outputs.
 * Assumes one aclk domain with a synchronous active-low aresetn.
 */
`timescale 1ns/1ps
`include "sbc_regs.svh"
module sbc_chk import sbc_pkg::*; (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Link
	input wire logic [2:0] bus_addr,
	input wire logic [9:0] bus_wdata,
	input wire logic       bus_wr,
	input wire logic       capture_gate,
	input wire logic       zero_cross_out,
	// Device outputs
	input wire logic       integrate,
	input wire logic       discharge_sw,
	input wire logic       conv_done
);
	logic [9:0] ctrl_q, ctrl_d;
	logic       zc_q, gate_q, co_q, co_d, fall, grise, gfall, sync, gated, cal;
	logic [1:0] gf_q, gf_d;
	logic [4:0] wf_q, wf_d, ncyc;
	logic [7:0] since_q, since_d, lo;
	logic [2:0] nbg_q, nbg_d, nb;

	// Shadow of the control image and edge counters
	always_comb begin
		fall = zc_q & ~zero_cross_out;
		grise = capture_gate & ~gate_q;
		gfall = gate_q & ~capture_gate;
		ctrl_d = (bus_wr && bus_addr == `SBC_DEV_CTRL) ? bus_wdata : ctrl_q;
		gf_d = !capture_gate ? 2'h0 : (fall && gf_q != 2'h3) ? gf_q + 2'h1 : gf_q;
		co_d = grise ? fall : co_q;
		wf_d = !integrate ? 5'h00 : fall ? wf_q + 5'h01 : wf_q;
		since_d = gfall ? 8'h00 : (since_q == 8'hFF) ? since_q : since_q + 8'h01;
		nbg_d = conv_done ? 3'h0 : gfall ? nbg_q + 3'h1 : nbg_q;
		ncyc = (ctrl_q[3:0] < `SBC_CYC_MIN) ? 5'h04 : {1'b0, ctrl_q[3:0]};
		nb = {1'b0, ctrl_q[7:6]} + 3'h1;
		lo = {5'h00, nb} * 8'h0E;
		sync = ctrl_q[5:4] == SBC_M_SYNC;
		gated = ctrl_q[5:4] == SBC_M_GATED;
		cal = ctrl_q[5:4] == SBC_M_CAL;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `SBC_CTRL_RST;
			{zc_q, gate_q, co_q, gf_q, wf_q, since_q, nbg_q} <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			{zc_q, gate_q, co_q, gf_q, wf_q, since_q, nbg_q} <=
				{zero_cross_out, capture_gate, co_d, gf_d, wf_d, since_d, nbg_d};
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	win_open_a: assert property ($rose(integrate) && sync |-> gf_q == 2'h2 || (co_q && gf_q == 2'h3))
		else $error("window opened on wrong zero-cross edge");
	win_len_a: assert property ($fell(integrate) && sync |-> wf_q == ncyc)
		else $error("window length wrong");
	conv_time_a: assert property ($rose(conv_done) |-> since_q inside {[lo + 8'h01 : lo + 8'h05]})
		else $error("conversion time wrong");
	done_pulse_a: assert property (conv_done |=> !conv_done [*8])
		else $error("done not a single pulse");
	burst_count_a: assert property ($rose(conv_done) |-> nbg_q == nb)
		else $error("wrong burst count before done");
	cal_open_a: assert property (cal && $past(cal) |-> !discharge_sw)
		else $error("discharge switch closed in calibration");
	gated_follow_a: assert property ($rose(capture_gate) && gated |-> ##[1:2] integrate)
		else $error("gated window did not follow gate");
	cal_follow_a: assert property ($rose(capture_gate) && cal |-> ##[1:2] integrate)
		else $error("calibration window did not follow gate");

	cover property ($rose(integrate) && sync);
	cover property (conv_done && nb == 3'h4);
	cover property (capture_gate && cal);
endmodule : sbc_chk

//--- dv/servo_burst_capture_sequencer_test.sv
/*
 * Self-checking bench: host and sequencer joined by sbc_if, driven over AXI4-Lite.
 * Assumes a 50 MHz aclk and a bench-made zero-cross square wave of four cycles.
 */
`timescale 1ns/1ps
`include "sbc_regs.svh"
module servo_burst_capture_sequencer_test;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, zc, gate_q;
	logic        awready, wready, bvalid, arready, rvalid, irq, integrate, dis_sw, done;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, zph;
	logic [9:0]  sample_in, sbase;
	int          bad_count, comparisons, cycles, bursts;

	sbc_if lnk ();
	assign lnk.zero_cross_out = zc;
	sbc_dev i_sbc_dev (.aclk(aclk), .aresetn(aresetn), .lnk(lnk), .sample_in(sample_in),
		.integrate(integrate), .discharge_sw(dis_sw), .conv_done(done));
	sbc_host i_sbc_host (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
		.s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .irq(irq), .lnk(lnk));
	sbc_chk i_sbc_chk (.aclk(aclk), .aresetn(aresetn), .bus_addr(lnk.bus_addr),
		.bus_wdata(lnk.bus_wdata), .bus_wr(lnk.bus_wr), .capture_gate(lnk.capture_gate),
		.zero_cross_out(zc), .integrate(integrate), .discharge_sw(dis_sw), .conv_done(done));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// Zero-cross wave, per-burst sample values, hang limit
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		zph <= zph + 2'h1;
		zc <= zph < 2'h2;
		gate_q <= lnk.capture_gate;
		if (lnk.capture_gate && !gate_q) begin
			sample_in <= sbase + 10'(bursts);
			bursts <= bursts + 1;
		end
		if (cycles == 20000) begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk("bresp", 32'h0, {30'h0, bresp});
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		chk("rresp", 32'h0, {30'h0, rresp});
		rready <= 1'b0;
	endtask : rd

	task automatic run_seq(input logic [10:0] c, input logic [31:0] t, input int nb);
		int n;
		sbase = c[9:0] ^ 10'h2A5;
		bursts = 0;
		n = 0;
		wr(`SBC_H_CTRL, {21'h0, c});
		wr(`SBC_H_TIME, t);
		wr(`SBC_H_IRQ_EN, 32'h1);
		wr(`SBC_H_CMD, 32'h1);
		rd(`SBC_H_STAT);
		chk("busy", 32'h1, d & 32'h1);
		while (irq !== 1'b1 && n < 5000) begin
			@(posedge aclk);
			n++;
		end
		chk("irq", 32'h1, {31'h0, irq});
		for (int k = 0; k < nb; k++) begin
			rd(8'(`SBC_H_DATA0 + 4 * k));
			chk("data", {22'h0, sbase + 10'(k)}, d);
		end
		rd(`SBC_H_STAT);
		chk("idle", 32'h0, d & 32'h1);
		wr(`SBC_H_IRQ_EN, 32'h0);
		rd(`SBC_H_IRQ_STAT);
		chk("irq_stat", 32'h1, d);
		chk("masked", 32'h0, {31'h0, irq});
		wr(`SBC_H_IRQ_CLR, 32'h1);
		rd(`SBC_H_IRQ_STAT);
		chk("cleared", 32'h0, d);
	endtask : run_seq

	task automatic wrap_up();
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, zc, gate_q, zph} = '0;
		{awaddr, araddr, wdata, sample_in, sbase} = '0;
		{bad_count, comparisons, cycles, bursts} = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`SBC_H_TIME);
		chk("time_reset", `SBC_TIME_RST, d);
		rd(8'h40);
		chk("unmapped", 32'h0, d);
		rd(`SBC_H_IRQ_STAT);
		chk("irq_reset", 32'h0, d);
		run_seq(11'h0CF, 32'h0008_0050, 4);
		run_seq(11'h014, 32'h0008_0010, 1);
		run_seq(11'h066, 32'h0008_0010, 2);
		run_seq(11'h482, 32'h0008_0030, 3);
		wrap_up();
	end
endmodule : servo_burst_capture_sequencer_test
